/* hbcs_pkg.sv */
package hbcs_pkg;

	// ----------------------------------------
	// configuration store geometry
	// ----------------------------------------
	localparam int unsigned NENT      = 8;
	localparam int unsigned CFG_W     = 8;
	localparam int unsigned NPORTS    = 4;

	// ----------------------------------------
	// addresses and codes
	// ----------------------------------------
	localparam logic [7:0]  CFG_DONE_ADDR = 8'hff;
	localparam logic [23:0] SIG_ADDR      = 24'h00fffa;
	localparam logic [15:0] EXEC_ADDR     = 16'h0000;
	localparam logic [31:0] SIG_WORD      = 32'h32444655;
	localparam logic [7:0]  CMD_READ      = 8'h03;
	localparam logic [7:0]  CMD_DREAD     = 8'h3b;

	// ----------------------------------------
	// serial read counts
	// ----------------------------------------
	localparam logic [5:0]  CMD_BITS   = 6'h20;
	localparam logic [5:0]  DUMMY_CLKS = 6'h08;
	localparam logic [5:0]  SIG_BITS   = 6'h20;

	// ----------------------------------------
	// entry 0 field positions and defaults
	// ----------------------------------------
	localparam int unsigned STRAP_LSB     = 0;
	localparam int unsigned BC_EN_BIT     = 2;
	localparam int unsigned SPI_DUAL_BIT  = 3;
	localparam int unsigned SPI_MODE3_BIT = 4;
	localparam logic [63:0] ROM_DEFAULTS  = 64'h0000_0000_0000_0008;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		STRAP_NONE  = 2'b00,
		STRAP_SMBUS = 2'b01,
		STRAP_UART  = 2'b10,
		STRAP_SPI   = 2'b11
	} hbcs_strap_t;

	typedef enum logic [3:0] {
		ST_STANDBY   = 4'h0,
		ST_SPI_INIT  = 4'h1,
		ST_SPI_CHECK = 4'h2,
		ST_CFG_RD    = 4'h3,
		ST_STRAP     = 4'h4,
		ST_SOC_CFG   = 4'h5,
		ST_CDC       = 4'h6,
		ST_OTP_CFG   = 4'h7,
		ST_IDLE      = 4'h8,
		ST_CHG_DET   = 4'h9,
		ST_CONNECT   = 4'ha,
		ST_NORMAL    = 4'hb
	} hbcs_stage_t;

	typedef enum logic [1:0] {
		RD_IDLE  = 2'b00,
		RD_CMD   = 2'b01,
		RD_DUMMY = 2'b10,
		RD_DATA  = 2'b11
	} hbcs_rd_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} hbcs_wr_t;

endpackage : hbcs_pkg

/* hbcs_spi_sig.sv */
`timescale 1ns/1ps
module hbcs_spi_sig
	import hbcs_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	// control
	input  wire logic start_in,
	input  wire logic dual_in,
	input  wire logic mode3_in,
	output logic      done_out,
	output logic      match_out,
	// flash pins
	input  wire logic spi_do_in,
	input  wire logic spi_di_in,
	output logic      spi_cs_n_out,
	output logic      spi_clk_out,
	output logic      spi_clk_oe_n_out,
	output logic      spi_do_out,
	output logic      spi_do_oe_n_out
);

	hbcs_rd_t    st_q;
	logic [31:0] sh_q;
	logic [31:0] in_q;
	logic [5:0]  cnt_q;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_q             <= RD_IDLE;
			sh_q             <= 32'h0;
			in_q             <= 32'h0;
			cnt_q            <= 6'h0;
			spi_clk_out      <= 1'b0;
			spi_cs_n_out     <= 1'b1;
			spi_clk_oe_n_out <= 1'b1;
			spi_do_out       <= 1'b0;
			spi_do_oe_n_out  <= 1'b1;
			done_out         <= 1'b0;
			match_out        <= 1'b0;
		end else begin
			done_out <= 1'b0;
			// data moves on the falling edge, sampled on the rising one
			if (st_q != RD_IDLE) begin
				spi_clk_out <= ~spi_clk_out;
			end
			unique case (st_q)
				RD_IDLE: begin
					spi_clk_out <= mode3_in;
					if (start_in) begin
						sh_q             <= {(dual_in ? CMD_DREAD : CMD_READ), SIG_ADDR} << 1;
						spi_do_out       <= dual_in ? CMD_DREAD[7] : CMD_READ[7];
						cnt_q            <= CMD_BITS - 6'h1;
						spi_clk_out      <= 1'b0;
						spi_cs_n_out     <= 1'b0;
						spi_clk_oe_n_out <= 1'b0;
						spi_do_oe_n_out  <= 1'b0;
						st_q             <= RD_CMD;
					end
				end
				RD_CMD: begin
					if (spi_clk_out) begin
						if (cnt_q == 6'h0) begin
							spi_do_oe_n_out <= 1'b1;
							cnt_q           <= dual_in ? DUMMY_CLKS - 6'h1 : SIG_BITS - 6'h1;
							st_q            <= dual_in ? RD_DUMMY : RD_DATA;
						end else begin
							spi_do_out <= sh_q[31];
							sh_q       <= sh_q << 1;
							cnt_q      <= cnt_q - 6'h1;
						end
					end
				end
				RD_DUMMY: begin
					if (spi_clk_out) begin
						cnt_q <= (cnt_q == 6'h0) ? (SIG_BITS >> 1) - 6'h1 : cnt_q - 6'h1;
						if (cnt_q == 6'h0) begin
							st_q <= RD_DATA;
						end
					end
				end
				RD_DATA: begin
					if (!spi_clk_out) begin
						in_q <= dual_in ? {in_q[29:0], spi_di_in, spi_do_in} : {in_q[30:0], spi_di_in};
					end else if (cnt_q == 6'h0) begin
						spi_clk_out      <= mode3_in;
						spi_cs_n_out     <= 1'b1;
						spi_clk_oe_n_out <= 1'b1;
						match_out        <= (in_q == SIG_WORD);
						done_out         <= 1'b1;
						st_q             <= RD_IDLE;
					end else begin
						cnt_q <= cnt_q - 6'h1;
					end
				end
			endcase
		end
	end

endmodule : hbcs_spi_sig

/* hbcs_cfg_merge.sv */
`timescale 1ns/1ps
module hbcs_cfg_merge
	import hbcs_pkg::*;
#(
	parameter int unsigned N = NENT,
	parameter int unsigned W = CFG_W
) (
	// clock and reset
	input  wire logic           sys_clk_in,
	input  wire logic           rst_n_in,
	// sources
	input  wire logic           start_in,
	input  wire logic [N*W-1:0] rom_in,
	input  wire logic [N*W-1:0] soc_in,
	input  wire logic [N-1:0]   soc_set_in,
	input  wire logic [N*W-1:0] otp_in,
	input  wire logic [N-1:0]   otp_set_in,
	// result
	output logic [N*W-1:0]      cfg_out,
	output logic                done_out
);

	// soc writes beat otp contents, which beat rom defaults
	for (genvar i = 0; i < N; i++) begin : g_ent
		always_ff @(posedge sys_clk_in) begin
			if (!rst_n_in) begin
				cfg_out[i*W +: W] <= '0;
			end else if (start_in) begin
				cfg_out[i*W +: W] <= soc_set_in[i] ? soc_in[i*W +: W] :
					otp_set_in[i] ? otp_in[i*W +: W] : rom_in[i*W +: W];
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			done_out <= 1'b0;
		end else begin
			done_out <= start_in;
		end
	end

endmodule : hbcs_cfg_merge

/* hbcs_sequencer.sv */
`timescale 1ns/1ps
module hbcs_sequencer
	import hbcs_pkg::*;
#(
	parameter int unsigned N       = NENT,
	parameter int unsigned W       = CFG_W,
	parameter int unsigned N_PORTS = NPORTS
) (
	// clock and reset
	input  wire logic           sys_clk_in,
	input  wire logic           rst_n_in,
	// pll
	input  wire logic           pll_lock_in,
	input  wire logic           ref_clk_ok_in,
	output logic                pll_run_out,
	// boot flash and strap pins
	input  wire logic           spi_clk_in,
	input  wire logic           spi_do_in,
	input  wire logic           spi_di_in,
	output logic                spi_cs_n_out,
	output logic                spi_clk_out,
	output logic                spi_clk_oe_n_out,
	output logic                spi_do_out,
	output logic                spi_do_oe_n_out,
	output logic                ext_rom_en_out,
	output logic [15:0]         ext_exec_addr_out,
	// configuring soc write port
	input  wire hbcs_wr_t       soc_wr_in,
	// otp contents
	input  wire logic [N*W-1:0] otp_data_in,
	input  wire logic [N-1:0]   otp_valid_in,
	input  wire logic           otp_host_acc_in,
	output logic                otp_single_out,
	// upstream side
	input  wire logic           vbus_in,
	input  wire logic           chg_det_done_in,
	input  wire logic           host_ready_in,
	input  wire logic           soft_disc_in,
	input  wire logic           mode_change_in,
	// status and control
	output hbcs_stage_t         stage_out,
	output logic [N*W-1:0]      cfg_out,
	output logic                cfg_valid_out,
	output logic                cdc_func_out,
	output logic                chg_det_out,
	output logic                suspend_out,
	output logic                attach_out,
	output logic                usb_oe_n_out,
	output logic [N_PORTS-1:0]  ports_en_out
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (N < 2 || W != 8 || N * W != 64) begin : g_bad_geom
		$error("hbcs_sequencer: entry count or width unsupported");
	end

	// ----------------------------------------
	// internal state
	// ----------------------------------------
	hbcs_stage_t    stage_q;
	hbcs_strap_t    strap_q;
	logic [N*W-1:0] rom_q;
	logic [W-1:0]   soc_mem_q [N];
	logic [N*W-1:0] soc_flat;
	logic [N-1:0]   soc_set_q;
	logic           kick_q;
	logic           rd_start;
	logic           rd_done;
	logic           rd_match;
	logic           mg_start;
	logic           mg_done;
	logic           soc_hit;
	logic           soc_end;
	logic           bc_en;
	hbcs_strap_t    strap_pins;

	assign strap_pins = hbcs_strap_t'({spi_do_in, spi_clk_in});
	assign bc_en      = cfg_out[BC_EN_BIT];

	// each sub-engine gets exactly one start per stage visit
	assign rd_start = (stage_q == ST_SPI_CHECK) && !kick_q;
	assign mg_start = (stage_q == ST_OTP_CFG) && !kick_q;

	assign soc_hit = (stage_q == ST_SOC_CFG) && soc_wr_in.en;
	assign soc_end = soc_hit && (soc_wr_in.addr == CFG_DONE_ADDR);

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			kick_q <= 1'b0;
		end else begin
			kick_q <= (stage_q == ST_SPI_CHECK) || (stage_q == ST_OTP_CFG);
		end
	end

	// ----------------------------------------
	// stage sequencer
	// ----------------------------------------
	// single stage register
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			stage_q <= ST_STANDBY;
		end else begin
			unique case (stage_q)
				ST_STANDBY: begin
					stage_q <= ST_SPI_INIT;
				end
				ST_SPI_INIT: begin
					if (pll_lock_in && ref_clk_ok_in) begin
						stage_q <= (strap_pins == STRAP_SPI) ? ST_SPI_CHECK : ST_CFG_RD;
					end
				end
				ST_SPI_CHECK: begin
					if (rd_done) begin
						stage_q <= ST_CFG_RD;
					end
				end
				ST_CFG_RD: begin
					stage_q <= ST_STRAP;
				end
				ST_STRAP: begin
					unique case (strap_pins)
						STRAP_SMBUS: stage_q <= ST_SOC_CFG;
						STRAP_UART:  stage_q <= ST_CDC;
						default:     stage_q <= ST_OTP_CFG;
					endcase
				end
				ST_SOC_CFG: begin
					if (soc_end) begin
						stage_q <= ST_OTP_CFG;
					end
				end
				ST_CDC: begin
					stage_q <= ST_OTP_CFG;
				end
				ST_OTP_CFG: begin
					if (mg_done) begin
						stage_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (vbus_in) begin
						stage_q <= bc_en ? ST_CHG_DET : ST_CONNECT;
					end
				end
				ST_CHG_DET: begin
					if (chg_det_done_in) begin
						stage_q <= ST_CONNECT;
					end
				end
				ST_CONNECT: begin
					if (!vbus_in) begin
						stage_q <= ST_IDLE;
					end else if (host_ready_in && !soft_disc_in) begin
						stage_q <= ST_NORMAL;
					end
				end
				ST_NORMAL: begin
					if (soft_disc_in) begin
						stage_q <= ST_CONNECT;
					end else if (!vbus_in || mode_change_in) begin
						stage_q <= ST_IDLE;
					end
				end
				default: begin
					stage_q <= ST_STANDBY;
				end
			endcase
		end
	end

	assign stage_out = stage_q;

	// ----------------------------------------
	// defaults and straps
	// ----------------------------------------
	// nothing survives reset
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rom_q <= ROM_DEFAULTS;
		end else if (stage_q == ST_SPI_INIT) begin
			rom_q <= ROM_DEFAULTS;
		end else if (stage_q == ST_CFG_RD) begin
			rom_q[STRAP_LSB +: 2] <= strap_q;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			strap_q <= STRAP_NONE;
		end else if (stage_q == ST_SPI_INIT || stage_q == ST_STRAP) begin
			strap_q <= strap_pins;
		end
	end

	// ----------------------------------------
	// soc settings store
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || stage_q == ST_SPI_INIT) begin
			soc_set_q <= '0;
		end else if (soc_hit && soc_wr_in.addr < 8'(N)) begin
			soc_set_q[soc_wr_in.addr[$clog2(N)-1:0]] <= 1'b1;
		end
	end

	for (genvar i = 0; i < N; i++) begin : g_soc
		always_ff @(posedge sys_clk_in) begin
			if (!rst_n_in) begin
				soc_mem_q[i] <= '0;
			end else if (soc_hit && soc_wr_in.addr == 8'(i)) begin
				soc_mem_q[i] <= soc_wr_in.data;
			end
		end
		assign soc_flat[i*W +: W] = soc_mem_q[i];
	end

	// ----------------------------------------
	// boot flash signature reader
	// ----------------------------------------
	// signature read
	hbcs_spi_sig u_spi_sig (
		.sys_clk_in       (sys_clk_in),
		.rst_n_in         (rst_n_in),
		.start_in         (rd_start),
		.dual_in          (rom_q[SPI_DUAL_BIT]),
		.mode3_in         (rom_q[SPI_MODE3_BIT]),
		.done_out         (rd_done),
		.match_out        (rd_match),
		.spi_do_in        (spi_do_in),
		.spi_di_in        (spi_di_in),
		.spi_cs_n_out     (spi_cs_n_out),
		.spi_clk_out      (spi_clk_out),
		.spi_clk_oe_n_out (spi_clk_oe_n_out),
		.spi_do_out       (spi_do_out),
		.spi_do_oe_n_out  (spi_do_oe_n_out)
	);

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ext_rom_en_out    <= 1'b0;
			ext_exec_addr_out <= 16'h0000;
		end else if (rd_done && rd_match) begin
			ext_rom_en_out    <= 1'b1;
			ext_exec_addr_out <= EXEC_ADDR;
		end
	end

	// ----------------------------------------
	// configuration merge
	// ----------------------------------------
	// combine three sources
	hbcs_cfg_merge #(
		.N (N),
		.W (W)
	) u_merge (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (mg_start),
		.rom_in     (rom_q),
		.soc_in     (soc_flat),
		.soc_set_in (soc_set_q),
		.otp_in     (otp_data_in),
		.otp_set_in (otp_valid_in),
		.cfg_out    (cfg_out),
		.done_out   (mg_done)
	);

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || stage_q == ST_SPI_INIT) begin
			cfg_valid_out <= 1'b0;
		end else if (mg_done) begin
			cfg_valid_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// standby outputs safe
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pll_run_out    <= 1'b0;
			ports_en_out   <= '0;
			usb_oe_n_out   <= 1'b1;
			attach_out     <= 1'b0;
			suspend_out    <= 1'b0;
			chg_det_out    <= 1'b0;
		end else begin
			pll_run_out    <= 1'b1;
			ports_en_out   <= {N_PORTS{stage_q == ST_NORMAL}};
			attach_out     <= (stage_q == ST_CONNECT || stage_q == ST_NORMAL) && vbus_in && !soft_disc_in;
			usb_oe_n_out   <= !((stage_q == ST_CONNECT || stage_q == ST_NORMAL) && vbus_in && !soft_disc_in);
			suspend_out    <= (stage_q == ST_IDLE) && !vbus_in;
			chg_det_out    <= (stage_q == ST_CHG_DET);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			cdc_func_out <= 1'b0;
		end else if (stage_q == ST_CDC) begin
			cdc_func_out <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			otp_single_out <= 1'b0;
		end else begin
			otp_single_out <= otp_host_acc_in;
		end
	end

endmodule : hbcs_sequencer

/* hbcs_sequencer_sva.sv */
`timescale 1ns/1ps
module hbcs_sequencer_sva
	import hbcs_pkg::*;
#(
	parameter int unsigned N       = NENT,
	parameter int unsigned W       = CFG_W,
	parameter int unsigned N_PORTS = NPORTS
) (
	// clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rst_n_in,
	// pins and config inputs
	input  wire logic               spi_clk_in,
	input  wire logic               spi_do_in,
	input  wire hbcs_wr_t           soc_wr_in,
	input  wire logic               otp_host_acc_in,
	input  wire logic               vbus_in,
	input  wire logic               chg_det_done_in,
	input  wire logic               soft_disc_in,
	input  wire logic               mode_change_in,
	// outputs watched
	input  wire hbcs_stage_t        stage_out,
	input  wire logic [N*W-1:0]     cfg_out,
	input  wire logic               pll_run_out,
	input  wire logic               otp_single_out,
	input  wire logic               suspend_out,
	input  wire logic               attach_out,
	input  wire logic               usb_oe_n_out,
	input  wire logic [N_PORTS-1:0] ports_en_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_standby;
		disable iff (1'b0) !rst_n_in |=> stage_out == ST_STANDBY && usb_oe_n_out && ports_en_out == '0 && !pll_run_out;
	endproperty
	a_standby: assert property (p_standby) else $error("standby outputs wrong");
	property p_release;
		$rose(rst_n_in) |=> stage_out == ST_SPI_INIT && pll_run_out;
	endproperty
	a_release: assert property (p_release) else $error("no boot check after release");
	property p_strap;
		stage_out == ST_STRAP |=> stage_out == ($past({spi_do_in, spi_clk_in}) == 2'b01 ? ST_SOC_CFG :
			$past({spi_do_in, spi_clk_in}) == 2'b10 ? ST_CDC : ST_OTP_CFG);
	endproperty
	a_strap: assert property (p_strap) else $error("strap route wrong");
	property p_soc_wait;
		stage_out == ST_SOC_CFG && !(soc_wr_in.en && soc_wr_in.addr == CFG_DONE_ADDR) |=> stage_out == ST_SOC_CFG;
	endproperty
	a_soc_wait: assert property (p_soc_wait) else $error("soc stage left early");
	property p_soc_done;
		stage_out == ST_SOC_CFG && soc_wr_in.en && soc_wr_in.addr == CFG_DONE_ADDR |=> stage_out == ST_OTP_CFG;
	endproperty
	a_soc_done: assert property (p_soc_done) else $error("done write ignored");
	property p_idle_route;
		stage_out == ST_IDLE && vbus_in |=> stage_out == (cfg_out[BC_EN_BIT] ? ST_CHG_DET : ST_CONNECT);
	endproperty
	a_idle_route: assert property (p_idle_route) else $error("idle exit wrong");
	property p_suspend;
		(stage_out == ST_IDLE && !vbus_in)[*2] |-> suspend_out;
	endproperty
	a_suspend: assert property (p_suspend) else $error("no suspend");
	property p_chg_done;
		stage_out == ST_CHG_DET && chg_det_done_in |=> stage_out == ST_CONNECT;
	endproperty
	a_chg_done: assert property (p_chg_done) else $error("detect exit wrong");
	property p_normal;
		stage_out == ST_NORMAL ##1 stage_out == ST_NORMAL |-> ports_en_out == '1 && attach_out && !usb_oe_n_out;
	endproperty
	a_normal: assert property (p_normal) else $error("normal outputs wrong");
	property p_soft_disc;
		stage_out inside {ST_NORMAL, ST_CONNECT} && soft_disc_in && vbus_in && !mode_change_in |=> stage_out == ST_CONNECT;
	endproperty
	a_soft_disc: assert property (p_soft_disc) else $error("soft disconnect ignored");
	property p_otp_single;
		otp_host_acc_in |=> otp_single_out;
	endproperty
	a_otp_single: assert property (p_otp_single) else $error("otp not single ended");
endmodule : hbcs_sequencer_sva

bind hbcs_sequencer hbcs_sequencer_sva #(.N(N), .W(W), .N_PORTS(N_PORTS)) u_sva (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .spi_clk_in(spi_clk_in), .spi_do_in(spi_do_in),
	.soc_wr_in(soc_wr_in), .otp_host_acc_in(otp_host_acc_in), .vbus_in(vbus_in),
	.chg_det_done_in(chg_det_done_in), .soft_disc_in(soft_disc_in), .mode_change_in(mode_change_in),
	.stage_out(stage_out), .cfg_out(cfg_out), .pll_run_out(pll_run_out), .otp_single_out(otp_single_out),
	.suspend_out(suspend_out), .attach_out(attach_out), .usb_oe_n_out(usb_oe_n_out),
	.ports_en_out(ports_en_out)
);

/* hbcs_flash_model.sv */
`timescale 1ns/1ps
module hbcs_flash_model
	import hbcs_pkg::*;
(
	// clock
	input  wire logic        sys_clk_in,
	// flash pins
	input  wire logic        cs_n_in,
	input  wire logic        sck_in,
	input  wire logic        mosi_in,
	input  wire logic [31:0] sig_in,
	output logic             io1_out,
	output logic             io0_out,
	output logic             io0_oe_n_out,
	output logic [31:0]      cmd_out
);
	logic [6:0] rise_q = 7'h00;
	logic       sck_q  = 1'b0;
	logic       inv_q  = 1'b0;
	logic       dual;
	int         idx;

	// ----------------------------------------
	// serial clock edges and command capture
	// ----------------------------------------
	// answers at serial clock rates up to half of sys_clk_in
	always_ff @(posedge sys_clk_in) begin
		sck_q <= sck_in;
		inv_q <= ~inv_q;
		if (cs_n_in) begin
			rise_q <= 7'h00;
		end else if (sck_in && !sck_q) begin
			rise_q <= rise_q + 7'h01;
			if (rise_q < 7'h20) begin
				cmd_out <= {cmd_out[30:0], mosi_in};
			end
		end
	end

	assign dual = cmd_out[31:24] == CMD_DREAD;
	assign idx  = int'(rise_q) - (dual ? 40 : 32);

	// ----------------------------------------
	// data out, released io1_out changes every cycle
	// ----------------------------------------
	// single or dual read
	always_comb begin
		io1_out      = inv_q;
		io0_out      = 1'b0;
		io0_oe_n_out = 1'b1;
		if (!cs_n_in && idx >= 0 && idx < (dual ? 16 : 32)) begin
			io1_out = dual ? sig_in[31 - 2 * idx] : sig_in[31 - idx];
			if (dual) begin
				io0_out      = sig_in[30 - 2 * idx];
				io0_oe_n_out = 1'b0;
			end
		end
	end
endmodule : hbcs_flash_model

/* test_hbcs_sequencer.sv */
`timescale 1ns/1ps
module test_hbcs_sequencer;
	import hbcs_pkg::*;
	logic                 sys_clk_in = 1'b0;
	logic                 rst_n_in = 1'b0;
	logic                 pll_lock_in = 1'b0;
	logic                 ref_clk_ok_in = 1'b1;
	logic                 spi_clk_in, spi_do_in, spi_di_in;
	logic                 spi_cs_n_out, spi_clk_out, spi_clk_oe_n_out, spi_do_out, spi_do_oe_n_out;
	logic                 ext_rom_en_out, otp_single_out, cfg_valid_out, cdc_func_out, chg_det_out;
	logic                 suspend_out, attach_out, usb_oe_n_out, pll_run_out;
	logic [15:0]          ext_exec_addr_out;
	hbcs_wr_t             soc_wr_in = '0;
	logic [63:0]          otp_data_in = '0;
	logic [7:0]           otp_valid_in = '0;
	logic                 otp_host_acc_in = 1'b0;
	logic                 vbus_in = 1'b0, chg_det_done_in = 1'b0, host_ready_in = 1'b0;
	logic                 soft_disc_in = 1'b0, mode_change_in = 1'b0;
	hbcs_stage_t          stage_out, last_st;
	logic [63:0]          cfg_out;
	logic [3:0]           ports_en_out;
	logic [1:0]           strap = 2'b00;
	logic [31:0]          sig = '0, f_cmd;
	logic                 f_io1, f_io0, f_io0_oe_n;
	hbcs_stage_t          exp_q[$];
	int                   failures = 0, n_compared = 0, cyc = 0;
	integer               seed = 32'hd86e;

	always #10 sys_clk_in = ~sys_clk_in;

	// strap pulls on the clock and data-out pins when nobody drives them
	assign spi_clk_in = spi_clk_oe_n_out ? strap[0] : spi_clk_out;
	assign spi_do_in  = !spi_do_oe_n_out ? spi_do_out : !f_io0_oe_n ? f_io0 : strap[1];
	assign spi_di_in  = f_io1;

	hbcs_sequencer u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .pll_lock_in(pll_lock_in),
		.ref_clk_ok_in(ref_clk_ok_in), .pll_run_out(pll_run_out), .spi_clk_in(spi_clk_in),
		.spi_do_in(spi_do_in), .spi_di_in(spi_di_in), .spi_cs_n_out(spi_cs_n_out), .spi_clk_out(spi_clk_out),
		.spi_clk_oe_n_out(spi_clk_oe_n_out), .spi_do_out(spi_do_out), .spi_do_oe_n_out(spi_do_oe_n_out),
		.ext_rom_en_out(ext_rom_en_out), .ext_exec_addr_out(ext_exec_addr_out), .soc_wr_in(soc_wr_in),
		.otp_data_in(otp_data_in), .otp_valid_in(otp_valid_in), .otp_host_acc_in(otp_host_acc_in),
		.otp_single_out(otp_single_out), .vbus_in(vbus_in), .chg_det_done_in(chg_det_done_in),
		.host_ready_in(host_ready_in), .soft_disc_in(soft_disc_in), .mode_change_in(mode_change_in),
		.stage_out(stage_out), .cfg_out(cfg_out), .cfg_valid_out(cfg_valid_out), .cdc_func_out(cdc_func_out),
		.chg_det_out(chg_det_out), .suspend_out(suspend_out), .attach_out(attach_out),
		.usb_oe_n_out(usb_oe_n_out), .ports_en_out(ports_en_out));

	hbcs_flash_model u_flash (.sys_clk_in(sys_clk_in), .cs_n_in(spi_cs_n_out), .sck_in(spi_clk_out),
		.mosi_in(spi_do_out), .sig_in(sig), .io1_out(f_io1), .io0_out(f_io0), .io0_oe_n_out(f_io0_oe_n),
		.cmd_out(f_cmd));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report();
		if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report

	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			last_st = ST_STANDBY;
		end else if (stage_out !== last_st) begin
			last_st = stage_out;
			chk(stage_out, exp_q.size() ? exp_q.pop_front() : 4'hf);
		end
	end

	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	task automatic tick();
		@(posedge sys_clk_in);
		#1;
		otp_host_acc_in = 1'($random(seed));
	endtask : tick

	task automatic wait_st(input hbcs_stage_t st);
		int k;
		k = 0;
		while (stage_out !== st && k < 3000) begin
			tick();
			k++;
		end
		if (k == 3000) failures++;
	endtask : wait_st

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		soc_wr_in = '{1'b1, a, d};
		tick();
	endtask : wr

	task automatic boot(input logic [1:0] s, input logic [31:0] sg, input logic bc);
		logic [63:0] e;
		logic [7:0]  sd;
		rst_n_in = 1'b0;
		strap = s;
		sig = sg;
		pll_lock_in = 1'b0;
		ref_clk_ok_in = 1'b0;
		otp_valid_in = 8'($random(seed)) | 8'h01;
		otp_data_in = {$random(seed), $random(seed)};
		otp_data_in[BC_EN_BIT] = bc;
		sd = 8'($random(seed));
		repeat (5) tick();
		chk(stage_out, ST_STANDBY);
		chk({pll_run_out, usb_oe_n_out, ports_en_out, spi_cs_n_out, cfg_valid_out}, 8'h42);
		chk({spi_clk_oe_n_out, spi_do_oe_n_out}, 2'b11);
		chk({cdc_func_out, ext_rom_en_out}, 2'b00);
		chk(exp_q.size(), 0);
		exp_q = {ST_SPI_INIT};
		if (s == 2'b11) exp_q.push_back(ST_SPI_CHECK);
		exp_q.push_back(ST_CFG_RD);
		exp_q.push_back(ST_STRAP);
		if (s == 2'b01) exp_q.push_back(ST_SOC_CFG);
		if (s == 2'b10) exp_q.push_back(ST_CDC);
		exp_q.push_back(ST_OTP_CFG);
		exp_q.push_back(ST_IDLE);
		rst_n_in = 1'b1;
		repeat (4) tick();
		pll_lock_in = 1'b1;
		wr(8'h05, 8'ha5);
		soc_wr_in.en = 1'b0;
		chk(stage_out, ST_SPI_INIT);
		ref_clk_ok_in = 1'b1;
		e = ROM_DEFAULTS;
		e[1:0] = s;
		for (int i = 0; i < NENT; i++) if (otp_valid_in[i]) e[i*8 +: 8] = otp_data_in[i*8 +: 8];
		if (s == 2'b01) begin
			wait_st(ST_SOC_CFG);
			repeat (60) tick();
			chk(stage_out, ST_SOC_CFG);
			wr(8'h02, sd);
			wr(8'h09, 8'h5a);
			wr(CFG_DONE_ADDR, 8'h00);
			soc_wr_in.en = 1'b0;
			e[23:16] = sd;
		end
		wait_st(ST_IDLE);
		repeat (2) tick();
		chk(cfg_out, e);
		chk({cfg_valid_out, suspend_out, ext_rom_en_out, cdc_func_out}, {2'b11, s == 2'b11 && sg == SIG_WORD, s == 2'b10});
		if (s == 2'b11) chk({f_cmd, ext_exec_addr_out}, {CMD_DREAD, SIG_ADDR, EXEC_ADDR});
	endtask : boot

	task automatic up(input logic bc, input logic mc);
		if (bc) exp_q.push_back(ST_CHG_DET);
		exp_q.push_back(ST_CONNECT);
		vbus_in = 1'b1;
		if (bc) begin
			wait_st(ST_CHG_DET);
			tick();
			chk(chg_det_out, 1'b1);
			chg_det_done_in = 1'b1;
			tick();
			chg_det_done_in = 1'b0;
		end
		wait_st(ST_CONNECT);
		repeat (3) tick();
		exp_q.push_back(ST_NORMAL);
		host_ready_in = 1'b1;
		wait_st(ST_NORMAL);
		repeat (2) tick();
		chk({ports_en_out, attach_out, usb_oe_n_out}, 6'h3e);
		exp_q.push_back(ST_CONNECT);
		exp_q.push_back(ST_NORMAL);
		soft_disc_in = 1'b1;
		repeat (8) tick();
		soft_disc_in = 1'b0;
		wait_st(ST_NORMAL);
		exp_q.push_back(ST_IDLE);
		if (mc) mode_change_in = 1'b1;
		else vbus_in = 1'b0;
		wait_st(ST_IDLE);
		vbus_in = 1'b0;
		mode_change_in = 1'b0;
		host_ready_in = 1'b0;
		repeat (3) tick();
		chk(stage_out, ST_IDLE);
	endtask : up

	initial begin
		boot(2'b11, SIG_WORD, 1'b1);
		up(1'b1, 1'b0);
		boot(2'b11, ~SIG_WORD, 1'b0);
		up(1'b0, 1'b1);
		boot(2'b01, SIG_WORD, 1'b1);
		up(1'b1, 1'b1);
		boot(2'b10, SIG_WORD, 1'b0);
		boot(2'b00, SIG_WORD, 1'b0);
		up(1'b0, 1'b0);
		chk(exp_q.size(), 0);
		final_report();
	end
endmodule : test_hbcs_sequencer
